// *** dv/dspf_dev_model.sv ***
// ----------------------------------------
// Device side of the control port
// ----------------------------------------
module dspf_dev_model (
   input  wire logic sclk_i,
   input  wire logic mosi_i,
   input  wire logic latch_n_i,
   output logic      miso_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0]  sh;
   logic [39:0] tx;
   logic [7:0]  cur_q[$];
   logic [7:0]  last_q[$];
   logic [11:0] loc;
   int          nbit;
   int          frames = 0;
   int          w;

   // Value width per location; no location reaches working memory
   function automatic int rd_w(input logic [11:0] a);
      if (a < 12'h400) return 28;
      if (a < 12'h800) return 40;
      if (a == 12'h81A || a == 12'h81B) return 24;
      if (a == 12'h81D || a == 12'h820) return 8;
      return 16;
   endfunction

   initial miso_o = 1'b0;

   always @(negedge latch_n_i) begin
      nbit = 0;
      cur_q = {};
   end

   // Frame ends on latch rise; released line shows inverse
   always @(posedge latch_n_i) begin
      last_q = cur_q;
      frames++;
      miso_o = ~miso_o;
   end

   // Header taken once; burst words follow without address
   always @(posedge sclk_i) begin
      sh = {sh[6:0], mosi_i};
      nbit++;
      if (nbit % 8 == 0) cur_q.push_back(sh);
      if (nbit == 24) begin
         loc = {cur_q[1][3:0], cur_q[2]};
         w = rd_w(loc);
         tx = ({loc, loc, loc, 4'h9} & ((40'h1 << w) - 40'h1)) << (40 - 8 * ((w + 7) / 8));
         if (!cur_q[0][0]) tx = 40'hA5A5A5A5A5;
      end
   end

   always @(negedge sclk_i) begin
      if (!latch_n_i) begin
         miso_o = tx[39];
         tx = {tx[38:0], ~tx[39]};
      end
   end
endmodule

// *** dv/dspf_host_ctrl_tb.sv ***
`include "dspf_params.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module dspf_host_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [4:0]  addr = 5'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        waitreq;
   logic        sclk;
   logic        mosi;
   logic        miso;
   logic        latch_n;
   int          bad_count = 0;
   int          check_count = 0;
   logic [31:0] st = 32'h6B9ADD60;
   logic [7:0]  exp_q[$];
   logic [11:0] locs[11] = '{12'h000, 12'h3FF, 12'h400, 12'h7FF, 12'h810, 12'h815,
                              12'h81A, 12'h81B, 12'h81C, 12'h81D, 12'h820};

   always #5 clk = ~clk;

   dspf_host_ctrl dut (
      .clk_sys_i(clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
      .avs_waitrequest_o(waitreq), .spi_sclk_o(sclk), .spi_mosi_o(mosi),
      .spi_miso_i(miso), .spi_frame_latch_n_o(latch_n));

   dspf_dev_model dev (.sclk_i(sclk), .mosi_i(mosi), .latch_n_i(latch_n), .miso_o(miso));

   // ----------------------------------------
   // Expectation helpers
   // ----------------------------------------
   function automatic logic [31:0] xs();
      st ^= st << 13;
      st ^= st >> 17;
      st ^= st << 5;
      return st;
   endfunction

   function automatic int exp_w(input logic [11:0] a, input logic r);
      if (a < 12'h400) return 28;
      if (a < 12'h800) return 40;
      if (a >= 12'h810 && a <= 12'h814) return 28;
      if (a >= 12'h815 && a <= 12'h819) return 10;
      if (a == 12'h81A || a == 12'h81B) return r ? 24 : 13;
      if (a == 12'h81D || a == 12'h820) return 8;
      return 16;
   endfunction

   task automatic push_data(input logic [11:0] a, input logic r, input logic [39:0] v);
      int          w;
      int          n;
      logic [39:0] m;
      w = exp_w(a, r);
      n = (!r && a >= 12'h810 && a <= 12'h814) ? 5 : (w + 7) / 8;
      m = v & ((40'h1 << w) - 40'h1);
      for (int k = n - 1; k >= 0; k--) exp_q.push_back(m[8*k +: 8]);
   endtask

   task automatic cmp_frame();
      `CHK("frame_len", exp_q.size(), dev.last_q.size())
      for (int k = 0; k < exp_q.size(); k++)
         `CHK("frame_byte", exp_q[k], dev.last_q[k])
   endtask

   // ----------------------------------------
   // Bus and word transfers
   // ----------------------------------------
   task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic word(input logic [11:0] a, input logic r, input logic h,
                       input logic [39:0] v, input logic [6:0] c);
      logic [31:0] q;
      int          n;
      bus(`DSPF_REG_WDATA_LO, 1'b1, v[31:0], q);
      bus(`DSPF_REG_WDATA_HI, 1'b1, {24'h0, v[39:32]}, q);
      n = dev.frames;
      bus(`DSPF_REG_CMD, 1'b1, {9'h0, c, 2'b00, h, r, a}, q);
      do begin
         bus(`DSPF_REG_STATUS, 1'b0, 32'h0, q);
      end while (q[0] !== 1'b0);
      while (!h && dev.frames == n) begin
         @(posedge clk);
      end
      if (h) `CHK("frame_open", 2'b10, q[1:0])
   endtask

   task automatic chk_read(input logic [11:0] a);
      logic [31:0] q;
      logic [39:0] e;
      logic [31:0] lm;
      int          n;
      e = {a, a, a, 4'h9} & ((40'h1 << exp_w(a, 1'b1)) - 40'h1);
      n = (exp_w(a, 1'b1) + 7) / 8;
      lm = (n >= 4) ? 32'hFFFFFFFF : (32'h1 << (8 * n)) - 32'h1;
      bus(`DSPF_REG_RDATA_LO, 1'b0, 32'h0, q);
      `CHK("rdata_lo", e[31:0] & lm, q & lm)
      bus(`DSPF_REG_RDATA_HI, 1'b0, 32'h0, q);
      if (n == 5) `CHK("rdata_hi", e[39:32], q[7:0])
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin : main
      logic [31:0] q;
      logic [39:0] v;
      logic [6:0]  c;
      logic [11:0] a;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      `CHK("latch_idle", 1'b1, latch_n)
      bus(`DSPF_REG_STATUS, 1'b0, 32'h0, q);
      `CHK("status_rst", 32'h0, q)
      bus(5'h18, 1'b0, 32'h0, q);
      `CHK("unmapped", 32'h0, q)
      foreach (locs[i]) begin
         for (int r = 0; r < 2; r++) begin
            a = locs[i];
            q = xs();
            c = q[30:24];
            v = {q[7:0], xs()};
            if (!(r == 1 && a >= 12'h810 && a <= 12'h819)) begin
               word(a, r[0], 1'b0, v, c);
               exp_q = '{{c, r[0]}, {4'h0, a[11:8]}, a[7:0]};
               push_data(a, r[0], (r == 1) ? 40'h0 : v);
               cmp_frame();
               if (r == 1) chk_read(a);
            end
         end
      end
      foreach (locs[s]) begin
         if (s == 1 || s == 3) begin
            q = xs();
            c = q[6:0];
            exp_q = '{{c, 1'b0}, {4'h0, locs[s][11:8]}, locs[s][7:0]};
            for (int j = 0; j < 3; j++) begin
               a = locs[s] + 12'(j);
               v = {q[15:8], xs()};
               word(a, 1'b0, j < 2, v, c);
               push_data(a, 1'b0, v);
            end
            cmp_frame();
            bus(`DSPF_REG_CMD, 1'b0, 32'h0, q);
            `CHK("cmd_back", {9'h0, c, 4'h0, a}, q)
         end
      end
      print_verdict();
   end

   initial begin
      #500000;
      bad_count++;
      print_verdict();
   end
endmodule

// *** logic/dspf_host_ctrl.sv ***
// Decided for this implementation: register access over Avalon-MM.
`include "dspf_params.svh"

module dspf_host_ctrl (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic [4:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   output logic             spi_sclk_o,
   output logic             spi_mosi_o,
   input  wire logic        spi_miso_i,
   output logic             spi_frame_latch_n_o
);

   dspf_pkg::dspf_state_t state_r, state_nxt;
   logic [6:0]  chip_r, chip_nxt;
   logic [11:0] loc_r, loc_nxt;
   logic        rd_r, rd_nxt;
   logic        hold_r, hold_nxt;
   logic        hdr_r, hdr_nxt;
   logic        open_r, open_nxt;
   logic        latch_n_r, latch_n_nxt;
   logic        start_r, start_nxt;
   logic [3:0]  idx_r, idx_nxt;
   logic [3:0]  total_r, total_nxt;
   logic [39:0] wdata_r, wdata_nxt;
   logic [39:0] rdata_r, rdata_nxt;
   logic [31:0] rdout_r, rdout_nxt;
   logic        wait_r, wait_nxt;
   logic        req, stall, wr_take, cmd_take;
   logic [2:0]  len;
   logic [39:0] mask;
   logic [39:0] word_m;
   logic [3:0]  hdr_n;
   logic [3:0]  data_idx;
   logic [2:0]  byte_sel;
   logic [7:0]  tx_byte;
   logic        sh_done;
   logic [7:0]  sh_rx;

   // ----------------------------------------
   // Word size decode and byte shifter
   // ----------------------------------------
   dspf_word_size u_size (
      .loc_i  (loc_r),
      .rd_i   (rd_r),
      .len_o  (len),
      .mask_o (mask)
   );

   dspf_spi_shift u_shift (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .start_i   (start_r),
      .tx_byte_i (tx_byte),
      .miso_i    (spi_miso_i),
      .sclk_o    (spi_sclk_o),
      .mosi_o    (spi_mosi_o),
      .done_o    (sh_done),
      .rx_byte_o (sh_rx)
   );

   // ----------------------------------------
   // Outgoing byte selection
   // ----------------------------------------
   assign hdr_n    = hdr_r ? `DSPF_HDR_BYTES : 4'h0;
   assign data_idx = idx_r - hdr_n;
   assign byte_sel = 3'(len - 3'h1 - data_idx[2:0]);
   assign word_m   = wdata_r & mask;

   always_comb begin
      tx_byte = 8'h00;
      if (hdr_r && idx_r == 4'h0) begin
         tx_byte = {chip_r, rd_r};
      end else if (hdr_r && idx_r == 4'h1) begin
         tx_byte = {4'h0, loc_r[11:8]};
      end else if (hdr_r && idx_r == 4'h2) begin
         tx_byte = loc_r[7:0];
      end else if (!rd_r) begin
         case (byte_sel)
            3'h0: tx_byte = word_m[7:0];
            3'h1: tx_byte = word_m[15:8];
            3'h2: tx_byte = word_m[23:16];
            3'h3: tx_byte = word_m[31:24];
            3'h4: tx_byte = word_m[39:32];
            default: tx_byte = 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // Avalon slave handshake
   // ----------------------------------------
   assign req      = avs_read_i | avs_write_i;
   assign stall    = avs_write_i & (state_r != dspf_pkg::DSPF_IDLE);
   assign wr_take  = avs_write_i & ~wait_r;
   assign cmd_take = wr_take & (avs_address_i == `DSPF_REG_CMD);

   always_comb begin
      wait_nxt  = ~(req & wait_r & ~stall);
      rdout_nxt = rdout_r;
      if (req & wait_r & ~stall) begin
         case (avs_address_i)
            `DSPF_REG_CMD:      rdout_nxt = {9'h000, chip_r, 2'h0, hold_r, rd_r, loc_r};
            `DSPF_REG_WDATA_LO: rdout_nxt = wdata_r[31:0];
            `DSPF_REG_WDATA_HI: rdout_nxt = {24'h000000, wdata_r[39:32]};
            `DSPF_REG_RDATA_LO: rdout_nxt = rdata_r[31:0];
            `DSPF_REG_RDATA_HI: rdout_nxt = {24'h000000, rdata_r[39:32]};
            `DSPF_REG_STATUS:   rdout_nxt = {4'h0, loc_r, 14'h0000, open_r,
                                             (state_r != dspf_pkg::DSPF_IDLE)};
            default:            rdout_nxt = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------
   // Frame sequencer
   // ----------------------------------------
   always_comb begin
      state_nxt   = state_r;
      chip_nxt    = chip_r;
      loc_nxt     = loc_r;
      rd_nxt      = rd_r;
      hold_nxt    = hold_r;
      hdr_nxt     = hdr_r;
      open_nxt    = open_r;
      latch_n_nxt = latch_n_r;
      start_nxt   = 1'b0;
      idx_nxt     = idx_r;
      total_nxt   = total_r;
      wdata_nxt   = wdata_r;
      rdata_nxt   = rdata_r;
      if (wr_take && avs_address_i == `DSPF_REG_WDATA_LO) begin
         wdata_nxt[31:0] = avs_writedata_i;
      end
      if (wr_take && avs_address_i == `DSPF_REG_WDATA_HI) begin
         wdata_nxt[39:32] = avs_writedata_i[7:0];
      end
      case (state_r)
         dspf_pkg::DSPF_IDLE: begin
            if (cmd_take) begin
               hold_nxt = avs_writedata_i[`DSPF_CMD_HOLD_BIT];
               if (open_r) begin
                  loc_nxt = loc_r + 12'h001;
                  hdr_nxt = 1'b0;
               end else begin
                  chip_nxt = avs_writedata_i[`DSPF_CMD_CHIP_MSB:`DSPF_CMD_CHIP_LSB];
                  rd_nxt   = avs_writedata_i[`DSPF_CMD_RD_BIT];
                  loc_nxt  = avs_writedata_i[`DSPF_CMD_LOC_MSB:0];
                  hdr_nxt  = 1'b1;
               end
               state_nxt = dspf_pkg::DSPF_SETUP;
            end
         end
         dspf_pkg::DSPF_SETUP: begin
            latch_n_nxt = 1'b0;
            idx_nxt     = 4'h0;
            rdata_nxt   = 40'h0000000000;
            total_nxt   = hdr_n + {1'b0, len};
            state_nxt   = dspf_pkg::DSPF_SEND;
         end
         dspf_pkg::DSPF_SEND: begin
            start_nxt = 1'b1;
            state_nxt = dspf_pkg::DSPF_WAIT;
         end
         dspf_pkg::DSPF_WAIT: begin
            if (sh_done) begin
               if (rd_r && idx_r >= hdr_n) begin
                  rdata_nxt = {rdata_r[31:0], sh_rx};
               end
               if (idx_r == total_r - 4'h1) begin
                  if (hold_r) begin
                     open_nxt  = 1'b1;
                     state_nxt = dspf_pkg::DSPF_IDLE;
                  end else begin
                     state_nxt = dspf_pkg::DSPF_CLOSE;
                  end
               end else begin
                  idx_nxt   = idx_r + 4'h1;
                  state_nxt = dspf_pkg::DSPF_SEND;
               end
            end
         end
         dspf_pkg::DSPF_CLOSE: begin
            latch_n_nxt = 1'b1;
            open_nxt    = 1'b0;
            state_nxt   = dspf_pkg::DSPF_IDLE;
         end
         default: begin
            state_nxt = dspf_pkg::DSPF_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r   <= dspf_pkg::DSPF_IDLE;
         chip_r    <= `DSPF_CHIP_RST;
         loc_r     <= 12'h000;
         rd_r      <= 1'b0;
         hold_r    <= 1'b0;
         hdr_r     <= 1'b0;
         open_r    <= 1'b0;
         latch_n_r <= 1'b1;
         start_r   <= 1'b0;
         idx_r     <= 4'h0;
         total_r   <= 4'h0;
         wdata_r   <= 40'h0000000000;
         rdata_r   <= 40'h0000000000;
         rdout_r   <= 32'h00000000;
         wait_r    <= 1'b1;
      end else begin
         state_r   <= state_nxt;
         chip_r    <= chip_nxt;
         loc_r     <= loc_nxt;
         rd_r      <= rd_nxt;
         hold_r    <= hold_nxt;
         hdr_r     <= hdr_nxt;
         open_r    <= open_nxt;
         latch_n_r <= latch_n_nxt;
         start_r   <= start_nxt;
         idx_r     <= idx_nxt;
         total_r   <= total_nxt;
         wdata_r   <= wdata_nxt;
         rdata_r   <= rdata_nxt;
         rdout_r   <= rdout_nxt;
         wait_r    <= wait_nxt;
      end
   end

   assign avs_readdata_o      = rdout_r;
   assign avs_waitrequest_o   = wait_r;
   assign spi_frame_latch_n_o = latch_n_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_last_byte;
      state_r == dspf_pkg::DSPF_WAIT && sh_done && idx_r == total_r - 4'h1 && !hold_r;
   endsequence

   chk_frame_close: assert property (s_last_byte |-> ##2 spi_frame_latch_n_o)
      else $error("latch did not rise after last byte");
   chk_frame_hold: assert property (open_r |-> !spi_frame_latch_n_o)
      else $error("latch high while burst frame open");
   chk_hdr_chip_byte: assert property (start_r && hdr_r && idx_r == 4'h0
      |-> tx_byte == {chip_r, rd_r})
      else $error("header byte 0 wrong");
   chk_hdr_zero_fill: assert property (start_r && hdr_r && idx_r == 4'h1
      |-> tx_byte[7:4] == 4'h0)
      else $error("header byte 1 not zero filled");
   chk_single_size: assert property (state_r == dspf_pkg::DSPF_SEND && hdr_r
      |-> total_r >= 4'h4 && total_r <= 4'h8)
      else $error("single message size out of range");
   chk_len_from_loc: assert property (state_r == dspf_pkg::DSPF_SEND
      |-> total_r == hdr_n + {1'b0, len})
      else $error("byte count not from location");
   chk_coef_pad: assert property (start_r && idx_r == hdr_n && !rd_r
      && loc_r < `DSPF_LOC_PROG_BASE |-> tx_byte[7:4] == 4'h0)
      else $error("coefficient pad bits not zero");
   chk_prog_size: assert property (state_r == dspf_pkg::DSPF_SEND
      && loc_r >= `DSPF_LOC_PROG_BASE && loc_r <= `DSPF_LOC_PROG_LAST |-> len == 3'h5)
      else $error("instruction word not five bytes");
   chk_burst_incr: assert property (cmd_take && open_r
      |=> loc_r == $past(loc_r) + 12'h001 && !hdr_r)
      else $error("burst location not advanced");
   chk_cap_setup: assert property (state_r == dspf_pkg::DSPF_SEND && !rd_r
      && loc_r == `DSPF_LOC_CAP_A |-> len == 3'h2 && mask[13] == 1'b0)
      else $error("capture setup size wrong");

endmodule

// *** logic/dspf_params.svh ***
`ifndef DSPF_PARAMS_SVH
`define DSPF_PARAMS_SVH

// ----------------------------------------
// Software register byte offsets
// ----------------------------------------
`define DSPF_REG_CMD        5'h00
`define DSPF_REG_WDATA_LO   5'h04
`define DSPF_REG_WDATA_HI   5'h08
`define DSPF_REG_RDATA_LO   5'h0C
`define DSPF_REG_RDATA_HI   5'h10
`define DSPF_REG_STATUS     5'h14

// ----------------------------------------
// Command register fields
// ----------------------------------------
`define DSPF_CMD_LOC_MSB    11
`define DSPF_CMD_RD_BIT     12
`define DSPF_CMD_HOLD_BIT   13
`define DSPF_CMD_CHIP_LSB   16
`define DSPF_CMD_CHIP_MSB   22

// ----------------------------------------
// Device location map
// ----------------------------------------
`define DSPF_LOC_PROG_BASE  12'h400
`define DSPF_LOC_PROG_LAST  12'h7FF
`define DSPF_LOC_SDATA_0    12'h810
`define DSPF_LOC_SDATA_4    12'h814
`define DSPF_LOC_SADR_0     12'h815
`define DSPF_LOC_SADR_4     12'h819
`define DSPF_LOC_CAP_A      12'h81A
`define DSPF_LOC_CAP_B      12'h81B
`define DSPF_LOC_RAMCFG     12'h81D
`define DSPF_LOC_SIN        12'h820

// ----------------------------------------
// Timing, header length and reset values
// ----------------------------------------
`define DSPF_SCLK_HALF      4'h6
`define DSPF_HDR_BYTES      4'h3
`define DSPF_CHIP_RST       7'h00

`endif

// *** logic/dspf_pkg.sv ***
package dspf_pkg;

   typedef enum logic [2:0] {
      DSPF_IDLE  = 3'b000,
      DSPF_SETUP = 3'b001,
      DSPF_SEND  = 3'b010,
      DSPF_WAIT  = 3'b011,
      DSPF_CLOSE = 3'b100
   } dspf_state_t;

   typedef enum logic [1:0] {
      DSPF_SH_IDLE = 2'b00,
      DSPF_SH_LOW  = 2'b01,
      DSPF_SH_HIGH = 2'b10
   } dspf_sh_state_t;

endpackage

// *** logic/dspf_spi_shift.sv ***
`include "dspf_params.svh"

module dspf_spi_shift (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   input  wire logic       start_i,
   input  wire logic [7:0] tx_byte_i,
   input  wire logic       miso_i,
   output logic            sclk_o,
   output logic            mosi_o,
   output logic            done_o,
   output logic      [7:0] rx_byte_o
);

   dspf_pkg::dspf_sh_state_t st_r, st_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [7:0] rx_r, rx_nxt;
   logic       sclk_r, sclk_nxt;
   logic       mosi_r, mosi_nxt;
   logic       done_r, done_nxt;
   logic       miso_m_r, miso_s_r;
   logic       tick;

   // ----------------------------------------
   // Input synchroniser
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         miso_m_r <= 1'b0;
         miso_s_r <= 1'b0;
      end else begin
         miso_m_r <= miso_i;
         miso_s_r <= miso_m_r;
      end
   end

   assign tick = (cnt_r == `DSPF_SCLK_HALF - 4'h1);

   // ----------------------------------------
   // Mode 0 byte shifter, MSB first
   // ----------------------------------------
   always_comb begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r + 4'h1;
      bit_nxt  = bit_r;
      sh_nxt   = sh_r;
      rx_nxt   = rx_r;
      sclk_nxt = sclk_r;
      mosi_nxt = mosi_r;
      done_nxt = 1'b0;
      case (st_r)
         dspf_pkg::DSPF_SH_IDLE: begin
            cnt_nxt = 4'h0;
            if (start_i) begin
               sh_nxt   = tx_byte_i;
               mosi_nxt = tx_byte_i[7];
               bit_nxt  = 3'h7;
               st_nxt   = dspf_pkg::DSPF_SH_LOW;
            end
         end
         dspf_pkg::DSPF_SH_LOW: begin
            if (tick) begin
               cnt_nxt  = 4'h0;
               sclk_nxt = 1'b1;
               rx_nxt   = {rx_r[6:0], miso_s_r};
               st_nxt   = dspf_pkg::DSPF_SH_HIGH;
            end
         end
         dspf_pkg::DSPF_SH_HIGH: begin
            if (tick) begin
               cnt_nxt  = 4'h0;
               sclk_nxt = 1'b0;
               if (bit_r == 3'h0) begin
                  done_nxt = 1'b1;
                  st_nxt   = dspf_pkg::DSPF_SH_IDLE;
               end else begin
                  bit_nxt  = bit_r - 3'h1;
                  sh_nxt   = {sh_r[6:0], 1'b0};
                  mosi_nxt = sh_r[6];
                  st_nxt   = dspf_pkg::DSPF_SH_LOW;
               end
            end
         end
         default: begin
            st_nxt = dspf_pkg::DSPF_SH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r   <= dspf_pkg::DSPF_SH_IDLE;
         cnt_r  <= 4'h0;
         bit_r  <= 3'h0;
         sh_r   <= 8'h00;
         rx_r   <= 8'h00;
         sclk_r <= 1'b0;
         mosi_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         bit_r  <= bit_nxt;
         sh_r   <= sh_nxt;
         rx_r   <= rx_nxt;
         sclk_r <= sclk_nxt;
         mosi_r <= mosi_nxt;
         done_r <= done_nxt;
      end
   end

   assign sclk_o    = sclk_r;
   assign mosi_o    = mosi_r;
   assign done_o    = done_r;
   assign rx_byte_o = rx_r;

   chk_msb_first: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (st_r == dspf_pkg::DSPF_SH_IDLE && start_i) |=> mosi_r == $past(tx_byte_i[7]))
      else $error("first bit out is not the byte MSB");

endmodule

// *** logic/dspf_word_size.sv ***
`include "dspf_params.svh"

module dspf_word_size (
   input  wire logic [11:0] loc_i,
   input  wire logic        rd_i,
   output logic      [2:0]  len_o,
   output logic      [39:0] mask_o
);

   logic [5:0] nbits;

   // ----------------------------------------
   // Byte count and value width per location
   // ----------------------------------------
   always_comb begin
      len_o = 3'h2;
      nbits = 6'h10;
      if (loc_i < `DSPF_LOC_PROG_BASE) begin
         len_o = 3'h4;
         nbits = 6'h1C;
      end else if (loc_i <= `DSPF_LOC_PROG_LAST) begin
         len_o = 3'h5;
         nbits = 6'h28;
      end else if (loc_i == `DSPF_LOC_CAP_A || loc_i == `DSPF_LOC_CAP_B) begin
         if (rd_i) begin
            len_o = 3'h3;
            nbits = 6'h18;
         end else begin
            len_o = 3'h2;
            nbits = 6'h0D;
         end
      end else if (loc_i >= `DSPF_LOC_SDATA_0 && loc_i <= `DSPF_LOC_SDATA_4) begin
         len_o = 3'h5;
         nbits = 6'h1C;
      end else if (loc_i >= `DSPF_LOC_SADR_0 && loc_i <= `DSPF_LOC_SADR_4) begin
         len_o = 3'h2;
         nbits = 6'h0A;
      end else if (loc_i == `DSPF_LOC_RAMCFG || loc_i == `DSPF_LOC_SIN) begin
         len_o = 3'h1;
         nbits = 6'h08;
      end else begin
         len_o = 3'h2;
         nbits = 6'h10;
      end
   end

   // ----------------------------------------
   // Zero fill above the value
   // ----------------------------------------
   generate
      for (genvar i = 0; i < 40; i++) begin : g_mask
         assign mask_o[i] = (6'(i) < nbits);
      end
   endgenerate

endmodule
